// [dea_pkg.sv]
// package: register selects, field layout, timing and structs for the data nonvolatile access block
package dea_pkg;
	// register selects on the special function register port
	localparam logic [1:0] DEA_SEL_INDEX   = 2'h0;
	localparam logic [1:0] DEA_SEL_HOLDER  = 2'h1;
	localparam logic [1:0] DEA_SEL_CONTROL = 2'h2;
	// cycle control bit positions
	localparam int DEA_BIT_FETCH_START   = 0;
	localparam int DEA_BIT_FETCH_PERMIT  = 1;
	localparam int DEA_BIT_PROG_START    = 2;
	localparam int DEA_BIT_PROG_PERMIT   = 3;
	localparam logic [3:0] DEA_CTRL_RESET = 4'h0;
	// fetch cycle length in clocks, program time and clock rate
	localparam int DEA_FETCH_CYCLES      = 2;
	localparam int DEA_PROG_TIME_US      = 4000;
	localparam int DEA_CLK_MHZ           = 200;
	localparam int DEA_PROG_CYCLES       = DEA_PROG_TIME_US * DEA_CLK_MHZ;

	typedef enum logic [1:0] {
		DEA_IDLE  = 2'b00,
		DEA_FETCH = 2'b01,
		DEA_PROG  = 2'b11,
		DEA_DONE  = 2'b10
	} dea_state_e;

	// register port request
	typedef struct packed {
		logic       wr;
		logic [1:0] sel;
		logic [7:0] wdata;
	} dea_req_s;
endpackage : dea_pkg

// [dea_array.sv]
// 64 by 8 storage array with registered read data
`timescale 1ns/1ps
module dea_array #(
	parameter int ADDR_W = 6
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_we,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [7:0]        i_wdata,
	output logic      [7:0]        o_rdata
);
	// the index register carries at most six address bits
	if (ADDR_W < 1 || ADDR_W > 6) begin : g_bad_addr
		$error("ADDR_W out of range");
	end

	logic [7:0] mem_q [2**ADDR_W];

	// write port and registered read port
	always_ff @(posedge i_sys_clk) begin
		if (i_we) begin
			mem_q[i_addr] <= i_wdata;
		end
		o_rdata <= mem_q[i_addr];
	end
endmodule : dea_array

// [dea_ctrl.sv]
// register control and cycle sequencing for the data nonvolatile access block
// Function
// - the location index holds six bits selecting one of 64 bytes and bits 7 and 6 read as zero.
// - no program cycle happens unless the program permit bit is one.
// - writing one to the program start bit stores the byte holder at the indexed location.
// - hardware clears the program start bit when the program cycle completes.
// - setting program start without program permit already set has no effect.
// - no fetch cycle happens unless the fetch permit bit is one.
// - writing one to the fetch start bit reads the byte at the indexed location.
// - hardware clears the fetch start bit when the fetch cycle ends.
// - the byte holder is an eight-bit readable and writable register with no defined reset value.
// - the fetched byte stays in the byte holder until another read or write.
// - setting fetch start without fetch permit already set begins no fetch.
// - the end of a program cycle raises the done flag and the multi-function request flag.
`timescale 1ns/1ps
module dea_ctrl
	import dea_pkg::*;
#(
	parameter int PROG_CYCLES = DEA_PROG_CYCLES
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst,
	input  wire logic             i_req_valid,
	input  wire dea_pkg::dea_req_s i_req,
	input  wire logic             i_done_clear,
	output logic      [7:0]       o_rdata,
	output logic                  o_nv_done_flag,
	output logic                  o_mf_request,
	output logic                  o_busy
);
	import dea_pkg::*;

	// refuse program times the 24-bit counter cannot hold
	if (PROG_CYCLES < 1 || PROG_CYCLES > 2**24 - 1) begin : g_bad_prog
		$error("PROG_CYCLES out of range");
	end

	typedef struct packed {
		dea_state_e  state;
		logic [5:0]  nv_location_index;
		logic [7:0]  nv_byte_holder;
		logic [3:0]  nv_cycle_control;
		logic [23:0] cnt;
		logic        done;
		logic        mf;
		logic [7:0]  rdata;
		logic        busy;
	} dea_st_s;

	dea_st_s     st_q;
	dea_st_s     st_d;
	logic [7:0]  arr_rdata;
	logic        arr_we;

	// register read mux
	function automatic logic [7:0] rd_mux(input logic [1:0] sel, input dea_st_s s);
		unique case (sel)
			DEA_SEL_INDEX:   rd_mux = {2'h0, s.nv_location_index};
			DEA_SEL_HOLDER:  rd_mux = s.nv_byte_holder;
			DEA_SEL_CONTROL: rd_mux = {4'h0, s.nv_cycle_control};
			default:         rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	// next state
	always_comb begin
		logic idle;
		logic wr_ctrl;
		idle    = 1'b0;
		wr_ctrl = 1'b0;
		st_d    = st_q;
		arr_we  = 1'b0;
		idle    = (st_q.state == DEA_IDLE);
		wr_ctrl = i_req_valid && i_req.wr && (i_req.sel == DEA_SEL_CONTROL);
		// done flag cleared by software, set wins below
		if (i_done_clear) begin
			st_d.done = 1'b0;
		end
		st_d.mf = 1'b0;
		st_d.rdata = rd_mux(i_req.sel, st_q);
		// index and holder frozen while busy
		if (i_req_valid && i_req.wr && idle) begin
			if (i_req.sel == DEA_SEL_INDEX) begin
				st_d.nv_location_index = i_req.wdata[5:0];
			end
			if (i_req.sel == DEA_SEL_HOLDER) begin
				st_d.nv_byte_holder = i_req.wdata;
			end
		end
		// permit bits always writable
		if (wr_ctrl) begin
			st_d.nv_cycle_control[DEA_BIT_PROG_PERMIT]  = i_req.wdata[DEA_BIT_PROG_PERMIT];
			st_d.nv_cycle_control[DEA_BIT_FETCH_PERMIT] = i_req.wdata[DEA_BIT_FETCH_PERMIT];
		end
		unique case (st_q.state)
			DEA_IDLE: begin
				// program start needs permit already set
				if (wr_ctrl && i_req.wdata[DEA_BIT_PROG_START] && st_q.nv_cycle_control[DEA_BIT_PROG_PERMIT]) begin
					st_d.nv_cycle_control[DEA_BIT_PROG_START] = 1'b1;
					st_d.cnt   = 24'(PROG_CYCLES - 1);
					st_d.state = DEA_PROG;
				// fetch start needs permit already set
				end else if (wr_ctrl && i_req.wdata[DEA_BIT_FETCH_START]
					&& st_q.nv_cycle_control[DEA_BIT_FETCH_PERMIT]) begin
					st_d.nv_cycle_control[DEA_BIT_FETCH_START] = 1'b1;
					st_d.cnt   = 24'(DEA_FETCH_CYCLES - 1);
					st_d.state = DEA_FETCH;
				end
			end
			DEA_FETCH: begin
				if (st_q.cnt == 24'h000000) begin
					st_d.nv_byte_holder = arr_rdata;
					st_d.nv_cycle_control[DEA_BIT_FETCH_START] = 1'b0;
					st_d.state = DEA_IDLE;
				end else begin
					st_d.cnt = st_q.cnt - 24'h000001;
				end
			end
			DEA_PROG: begin
				if (st_q.cnt == 24'h000000) begin
					arr_we     = 1'b1;
					st_d.state = DEA_DONE;
				end else begin
					st_d.cnt = st_q.cnt - 24'h000001;
				end
			end
			DEA_DONE: begin
				st_d.nv_cycle_control[DEA_BIT_PROG_START] = 1'b0;
				st_d.done  = 1'b1;
				st_d.mf    = 1'b1;
				st_d.state = DEA_IDLE;
			end
		endcase
		// busy registered so the output comes from a flop
		st_d.busy = st_d.nv_cycle_control[DEA_BIT_FETCH_START] | st_d.nv_cycle_control[DEA_BIT_PROG_START];
	end

	// state register
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_q.state             <= DEA_IDLE;
			st_q.nv_cycle_control  <= DEA_CTRL_RESET;
			st_q.cnt               <= 24'h000000;
			st_q.done              <= 1'b0;
			st_q.mf                <= 1'b0;
			st_q.rdata             <= 8'h00;
			st_q.busy              <= 1'b0;
			st_q.nv_location_index <= st_d.nv_location_index;
			st_q.nv_byte_holder    <= st_d.nv_byte_holder;
		end else begin
			st_q <= st_d;
		end
	end

	dea_array #(
		.ADDR_W(6)
	) u_array (
		.i_sys_clk(i_sys_clk),
		.i_we     (arr_we),
		.i_addr   (st_q.nv_location_index),
		.i_wdata  (st_q.nv_byte_holder),
		.o_rdata  (arr_rdata)
	);

	assign o_rdata        = st_q.rdata;
	assign o_nv_done_flag = st_q.done;
	assign o_mf_request   = st_q.mf;
	assign o_busy         = st_q.busy;

	a_prog_needs_permit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(st_q.state == DEA_IDLE && i_req_valid && i_req.wr && i_req.sel == DEA_SEL_CONTROL
		 && i_req.wdata[DEA_BIT_PROG_START] && !st_q.nv_cycle_control[DEA_BIT_PROG_PERMIT])
		|=> !st_q.nv_cycle_control[DEA_BIT_PROG_START]) else $error("program started without permit");
	a_fetch_needs_permit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(st_q.state == DEA_IDLE && i_req_valid && i_req.wr && i_req.sel == DEA_SEL_CONTROL
		 && i_req.wdata[DEA_BIT_FETCH_START] && !i_req.wdata[DEA_BIT_PROG_START]
		 && !st_q.nv_cycle_control[DEA_BIT_FETCH_PERMIT])
		|=> !st_q.nv_cycle_control[DEA_BIT_FETCH_START]) else $error("fetch started without permit");
	a_fetch_clears: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$rose(st_q.nv_cycle_control[DEA_BIT_FETCH_START]) |-> ##2 $fell(st_q.nv_cycle_control[DEA_BIT_FETCH_START]))
		else $error("fetch start not cleared on time");
	a_fetch_loads: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(st_q.nv_cycle_control[DEA_BIT_FETCH_START]) |-> st_q.nv_byte_holder == $past(arr_rdata))
		else $error("fetched byte not in holder");
	a_done_on_end: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		$fell(st_q.nv_cycle_control[DEA_BIT_PROG_START]) |-> st_q.done && st_q.mf)
		else $error("done flag missing at program end");
	a_done_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_nv_done_flag && !i_done_clear |=> o_nv_done_flag) else $error("done flag dropped");
	a_mf_single: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_mf_request |=> !o_mf_request) else $error("request longer than one cycle");
	// program start clears the cycle after the done state
	a_prog_clears: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		arr_we |-> ##2 $fell(st_q.nv_cycle_control[DEA_BIT_PROG_START])) else $error("program start not cleared");
	a_holder_frozen: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(st_q.state == DEA_PROG || st_q.state == DEA_DONE) |=> $stable(st_q.nv_byte_holder))
		else $error("holder moved in program");
	a_index_frozen: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_busy && st_q.state != DEA_IDLE |=> $stable(st_q.nv_location_index)) else $error("index moved in cycle");
	a_index_upper: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_req.sel == DEA_SEL_INDEX) |=> o_rdata[7:6] == 2'h0) else $error("index upper bits not zero");
	// write happens only when program was armed
	a_write_armed: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		arr_we |-> st_q.nv_cycle_control[DEA_BIT_PROG_START] && st_q.state == DEA_PROG) else $error("stray write");
	a_reset_ctrl: assert property (@(posedge i_sys_clk) $fell(i_rst) |-> st_q.nv_cycle_control == 4'h0)
		else $error("control not cleared by reset");

	c_fetch: cover property (@(posedge i_sys_clk) disable iff (i_rst) $fell(st_q.nv_cycle_control[DEA_BIT_FETCH_START]));
	c_prog: cover property (@(posedge i_sys_clk) disable iff (i_rst) arr_we);
	c_done_clear: cover property (@(posedge i_sys_clk) disable iff (i_rst) st_q.done && i_done_clear);
endmodule : dea_ctrl

// [dea_tb.sv]
// self-checking testbench for the data nonvolatile access control block
`timescale 1ns/1ps
module tb;
	import dea_pkg::*;
	localparam int PROG_N = 12;
	logic       i_sys_clk;
	logic       i_rst;
	logic       i_req_valid;
	logic       i_done_clear;
	dea_req_s   i_req;
	logic [7:0] o_rdata;
	logic       o_nv_done_flag;
	logic       o_mf_request;
	logic       o_busy;
	int         failures;
	int         checked;
	int         cycles;
	int         mf_cnt;
	logic [7:0] mem [64];
	logic [5:0] addrs [$];
	logic [7:0] rd;

	dea_ctrl #(.PROG_CYCLES(PROG_N)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
		.i_req(i_req), .i_done_clear(i_done_clear), .o_rdata(o_rdata), .o_nv_done_flag(o_nv_done_flag),
		.o_mf_request(o_mf_request), .o_busy(o_busy));

	// clock generation
	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	// hang guard and completion pulse counter
	always @(negedge i_sys_clk) begin
		cycles++;
		if (o_mf_request === 1'b1) mf_cnt++;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// expected control readback with no cycle running
	function automatic logic [7:0] ctrl_idle(input logic pp, input logic fp);
		ctrl_idle = 8'h00;
		ctrl_idle[DEA_BIT_PROG_PERMIT]  = pp;
		ctrl_idle[DEA_BIT_FETCH_PERMIT] = fp;
	endfunction : ctrl_idle

	// one register access then one idle cycle; sel held so the registered read data can be taken
	task automatic acc(input logic wr, input logic [1:0] sel, input logic [7:0] wd);
		i_req_valid = 1'b1;
		i_req = '{wr, sel, wd};
		@(negedge i_sys_clk);
		rd = o_rdata;
		i_req_valid = 1'b0;
		@(negedge i_sys_clk);
	endtask : acc

	task automatic wait_idle(input int lim);
		int n;
		n = 0;
		while (o_busy !== 1'b0 && n < lim) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk("busy", 8'h00, {7'h00, o_busy});
	endtask : wait_idle

	// program one byte, poking index, holder and fetch start while the cycle runs
	task automatic prog(input logic [5:0] a, input logic [7:0] d);
		int m;
		m = mf_cnt;
		acc(1'b1, DEA_SEL_INDEX, {2'h0, a});
		acc(1'b1, DEA_SEL_HOLDER, d);
		acc(1'b1, DEA_SEL_CONTROL, 8'h08);
		acc(1'b1, DEA_SEL_CONTROL, 8'h0C);
		chk("busy_prog", 8'h01, {7'h00, o_busy});
		acc(1'b1, DEA_SEL_INDEX, {2'h0, ~a});
		acc(1'b1, DEA_SEL_HOLDER, ~d);
		acc(1'b1, DEA_SEL_CONTROL, 8'h0A);
		acc(1'b1, DEA_SEL_CONTROL, 8'h0B);
		wait_idle(PROG_N + 10);
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("ctrl_after_prog", ctrl_idle(1'b1, 1'b1), rd);
		acc(1'b0, DEA_SEL_INDEX, 8'h00);
		chk("index_held", {2'h0, a}, rd);
		acc(1'b0, DEA_SEL_HOLDER, 8'h00);
		chk("holder_held", d, rd);
		chk("done_flag", 8'h01, {7'h00, o_nv_done_flag});
		chk("mf_pulses", 8'h01, 8'(mf_cnt - m));
		i_done_clear = 1'b1;
		@(negedge i_sys_clk);
		i_done_clear = 1'b0;
		chk("done_cleared", 8'h00, {7'h00, o_nv_done_flag});
		mem[a] = d;
		addrs.push_back(a);
	endtask : prog

	// fetch one byte and compare with the stored copy
	task automatic fetch(input logic [5:0] a);
		acc(1'b1, DEA_SEL_INDEX, {2'h0, a});
		acc(1'b1, DEA_SEL_HOLDER, ~mem[a]);
		acc(1'b1, DEA_SEL_CONTROL, 8'h02);
		acc(1'b1, DEA_SEL_CONTROL, 8'h03);
		wait_idle(10);
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("ctrl_after_fetch", ctrl_idle(1'b0, 1'b1), rd);
		acc(1'b0, DEA_SEL_HOLDER, 8'h00);
		chk("fetched_byte", mem[a], rd);
		acc(1'b0, DEA_SEL_HOLDER, 8'h00);
		chk("fetched_kept", mem[a], rd);
	endtask : fetch

	// main sequence
	initial begin
		void'($urandom(32'h8616));
		i_rst = 1'b1;
		i_req_valid = 1'b0;
		i_done_clear = 1'b0;
		i_req = '0;
		repeat (12) @(negedge i_sys_clk);
		i_rst = 1'b0;
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("ctrl_reset", 8'h00, rd);
		chk("done_reset", 8'h00, {7'h00, o_nv_done_flag});
		acc(1'b1, DEA_SEL_INDEX, 8'hFF);
		acc(1'b0, DEA_SEL_INDEX, 8'h00);
		chk("index_width", 8'h3F, rd);
		acc(1'b1, DEA_SEL_HOLDER, 8'hA5);
		acc(1'b0, DEA_SEL_HOLDER, 8'h00);
		chk("holder_rw", 8'hA5, rd);
		acc(1'b1, DEA_SEL_CONTROL, 8'h04);
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("prog_no_permit", 8'h00, rd);
		acc(1'b1, DEA_SEL_CONTROL, 8'h01);
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("fetch_no_permit", 8'h00, rd);
		acc(1'b1, DEA_SEL_CONTROL, 8'h0C);
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("prog_same_write", 8'h08, rd);
		acc(1'b1, DEA_SEL_CONTROL, 8'h03);
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("fetch_same_write", 8'h02, rd);
		acc(1'b1, DEA_SEL_CONTROL, 8'h06);
		acc(1'b0, DEA_SEL_CONTROL, 8'h00);
		chk("prog_permit_off", 8'h02, rd);
		chk("no_done", 8'h00, {7'h00, o_nv_done_flag});
		prog(6'h00, 8'h00);
		prog(6'h3F, 8'hFF);
		for (int i = 0; i < 6; i++) prog(6'($urandom), 8'($urandom));
		foreach (addrs[i]) fetch(addrs[i]);
		conclude();
	end
endmodule : tb
